// *** inc/cie_pkg.sv ***
// Functional notes
// - Quick move sign-extends a 4-bit instruction constant to operand size.
// - Zero-extend moves fill upper bits with zero; sign-extend moves copy sign.
// - Block copy and block compare walk a given count of bytes.
// - Add and subtract with carry include the carry flag, borrow on subtract.
// - Zero-rounded ratio truncates toward zero; residue matches that quotient.
// - Floor ratio rounds toward minus infinity; residue matches floored quotient.
// - Wide product gives double length; wide quotient divides double-length dividend.
// - Lsb invert flips bit zero only; all-bits invert flips every bit.
// - Condition save writes one or zero sized to operand length.
// - Shifts and rotate go left or right by signed count.
// - Bit test reads a bit, optionally sets, clears or inverts it atomically.
// - Field read extracts an unaligned field and right-aligns it.
// - Field write inserts an aligned value at any bit position.
// - Array step: accumulator times length plus index; bounds test checks limits.
// - Strings use R0 count, R1 and R2 pointers, R3 table, R4 value.
// - Backward option decrements string pointers each step.
// - Until option ends when string 1 element equals R4.
// - While option ends when string 1 element differs from R4.
// - Each string step decrements R0; ends when it reaches zero.
// - Translating variants map string 1 bytes through the R3 table.
// - Dedicated load or store is privileged for state word and vector base.
// - State bit set or clear is privileged unless byte length.
// - Length suffix selects byte, word or double-word operands.
// - Short operand is a 4-bit value inside the instruction.
package cie_pkg;
    localparam int         DW = 32;
    localparam logic [1:0] LEN_BYTE = 2'h0;
    localparam logic [1:0] LEN_WORD = 2'h1;
    localparam logic [1:0] LEN_DBL  = 2'h3;
    localparam logic [4:0] OP_MOVE      = 5'h00;
    localparam logic [4:0] OP_QUICK     = 5'h01;
    localparam logic [4:0] OP_ZEXT      = 5'h02;
    localparam logic [4:0] OP_SEXT      = 5'h03;
    localparam logic [4:0] OP_ADDC      = 5'h04;
    localparam logic [4:0] OP_SUBC      = 5'h05;
    localparam logic [4:0] OP_ZRATIO    = 5'h06;
    localparam logic [4:0] OP_ZRESID    = 5'h07;
    localparam logic [4:0] OP_FRATIO    = 5'h08;
    localparam logic [4:0] OP_FRESID    = 5'h09;
    localparam logic [4:0] OP_WIDEMUL   = 5'h0a;
    localparam logic [4:0] OP_WIDEDIV   = 5'h0b;
    localparam logic [4:0] OP_LSBINV    = 5'h0c;
    localparam logic [4:0] OP_ALLINV    = 5'h0d;
    localparam logic [4:0] OP_CONDSAVE  = 5'h0e;
    localparam logic [4:0] OP_LSHIFT    = 5'h0f;
    localparam logic [4:0] OP_ASHIFT    = 5'h10;
    localparam logic [4:0] OP_ROT       = 5'h11;
    localparam logic [4:0] OP_BITTEST   = 5'h12;
    localparam logic [4:0] OP_FREAD     = 5'h13;
    localparam logic [4:0] OP_FWRITE    = 5'h14;
    localparam logic [4:0] OP_ASTEP     = 5'h15;
    localparam logic [4:0] OP_BOUNDS    = 5'h16;
    localparam logic [4:0] OP_DREG_LD   = 5'h17;
    localparam logic [4:0] OP_DREG_ST   = 5'h18;
    localparam logic [4:0] OP_SBITS_SET = 5'h19;
    localparam logic [4:0] OP_SBITS_CLR = 5'h1a;
    localparam logic [4:0] OP_STR_COPY  = 5'h1b;
    localparam logic [4:0] OP_STR_CMP   = 5'h1c;
    localparam logic [4:0] OP_STR_SKIP  = 5'h1d;
    localparam logic [4:0] OP_BLK_COPY  = 5'h1e;
    localparam logic [4:0] OP_BLK_CMP   = 5'h1f;
    // Bit-test modifiers
    localparam logic [1:0] BT_TEST = 2'h0;
    localparam logic [1:0] BT_SET  = 2'h1;
    localparam logic [1:0] BT_CLR  = 2'h2;
    localparam logic [1:0] BT_INV  = 2'h3;
    // Dedicated register selectors needing privilege
    localparam logic [3:0] DREG_STATE = 4'ha;
    localparam logic [3:0] DREG_VBASE = 4'hb;
    // String option: 00 none, 01 while, 11 until
    localparam logic [1:0] OPT_NONE  = 2'h0;
    localparam logic [1:0] OPT_WHILE = 2'h1;
    localparam logic [1:0] OPT_UNTIL = 2'h3;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_READ = 4'h2,
        ST_WRIT = 4'h4,
        ST_DONE = 4'h8
    } cie_state_type;
endpackage : cie_pkg

// *** design/cie_exec.sv ***
`timescale 1ns/10ps
module cie_exec (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    // Command
    input  wire logic        start_i,
    input  wire logic [4:0]  op_i,
    input  wire logic [1:0]  len_i,
    input  wire logic [31:0] src_i,
    input  wire logic [31:0] dst_i,
    input  wire logic [31:0] ext_i,
    input  wire logic [3:0]  short_i,
    input  wire logic        cond_i,
    input  wire logic        carry_i,
    input  wire logic [1:0]  bt_mode_i,
    input  wire logic [4:0]  fpos_i,
    input  wire logic [5:0]  flen_i,
    input  wire logic [3:0]  dreg_i,
    input  wire logic        user_mode_i,
    // String options and registers
    input  wire logic        backward_i,
    input  wire logic [1:0]  str_opt_i,
    input  wire logic        translate_i,
    input  wire logic [31:0] r0_i,
    input  wire logic [31:0] r1_i,
    input  wire logic [31:0] r2_i,
    input  wire logic [31:0] r3_i,
    input  wire logic [31:0] r4_i,
    // Memory byte port
    output logic             mem_req_o,
    output logic             mem_we_o,
    output logic [31:0]      mem_addr_o,
    output logic [7:0]       mem_wdata_o,
    input  wire logic        mem_ack_i,
    input  wire logic [7:0]  mem_rdata_i,
    // Results
    output logic             done_o,
    output logic [31:0]      res_o,
    output logic [31:0]      res_hi_o,
    output logic             carry_o,
    output logic             flag_o,
    output logic             trap_o,
    output logic [31:0]      r0_o,
    output logic [31:0]      r1_o,
    output logic [31:0]      r2_o
);
    // ------------------------------------------------------------
    // Operand sizing
    // ------------------------------------------------------------
    wire logic [31:0] mask_w;
    wire logic [31:0] sgnbit_w;
    wire logic [5:0]  nbits_w;
    assign mask_w   = (len_i == cie_pkg::LEN_BYTE) ? 32'h0000_00ff :
                      (len_i == cie_pkg::LEN_WORD) ? 32'h0000_ffff : 32'hffff_ffff;
    assign nbits_w  = (len_i == cie_pkg::LEN_BYTE) ? 6'h08 :
                      (len_i == cie_pkg::LEN_WORD) ? 6'h10 : 6'h20;
    assign sgnbit_w = (mask_w >> 1) + 32'h1;

    function automatic logic [31:0] sext(input logic [31:0] v, input logic [31:0] m,
                                         input logic [31:0] s);
        sext = ((v & s) != 32'h0) ? (v | ~m) : (v & m);
    endfunction : sext

    wire logic signed [31:0] a_s;
    wire logic signed [31:0] b_s;
    assign a_s = sext(src_i, mask_w, sgnbit_w);
    assign b_s = sext(dst_i, mask_w, sgnbit_w);

    // ------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------
    wire logic [32:0] addc_w;
    wire logic [32:0] subc_w;
    assign addc_w = {1'b0, dst_i & mask_w} + {1'b0, src_i & mask_w} + {32'h0, carry_i};
    assign subc_w = {1'b0, dst_i & mask_w} - {1'b0, src_i & mask_w} - {32'h0, carry_i};
    wire logic carry_out_w;
    assign carry_out_w = (op_i == cie_pkg::OP_ADDC) ? ((addc_w[31:0] & ~mask_w) != 32'h0
                         || addc_w[32]) : ((subc_w[31:0] & ~mask_w) != 32'h0 || subc_w[32]);

    wire logic        div_zero_w;
    wire logic signed [31:0] zq_w;
    wire logic signed [31:0] zr_w;
    wire logic        fadj_w;
    wire logic signed [31:0] fq_w;
    wire logic signed [31:0] fr_w;
    assign div_zero_w = (a_s == 32'sh0);
    assign zq_w  = div_zero_w ? 32'sh0 : b_s / a_s;
    assign zr_w  = div_zero_w ? 32'sh0 : b_s % a_s;
    assign fadj_w = (zr_w != 32'sh0) && (zr_w[31] != a_s[31]);
    assign fq_w  = fadj_w ? zq_w - 32'sh1 : zq_w;
    assign fr_w  = fadj_w ? zr_w + a_s : zr_w;

    wire logic [63:0] wmul_w;
    wire logic [63:0] wdiv_n_w;
    wire logic [31:0] wdiv_q_w;
    wire logic [31:0] wdiv_r_w;
    assign wmul_w   = {32'h0, dst_i & mask_w} * {32'h0, src_i & mask_w};
    assign wdiv_n_w = (len_i == cie_pkg::LEN_DBL) ? {ext_i, dst_i} :
                      ({32'h0, ext_i & mask_w} << nbits_w) | {32'h0, dst_i & mask_w};
    assign wdiv_q_w = div_zero_w ? 32'h0 : 32'(wdiv_n_w / {32'h0, src_i & mask_w});
    assign wdiv_r_w = div_zero_w ? 32'h0 : 32'(wdiv_n_w % {32'h0, src_i & mask_w});

    // ------------------------------------------------------------
    // Shifts, bits and fields
    // ------------------------------------------------------------
    wire logic signed [7:0] cnt_w;
    wire logic [4:0]  amt_w;
    wire logic [31:0] lsh_w;
    wire logic [31:0] ash_w;
    wire logic [31:0] rot_w;
    wire logic [4:0]  rot_l_w;
    assign cnt_w = src_i[7:0];
    assign amt_w = cnt_w[7] ? 5'(-cnt_w) : cnt_w[4:0];
    assign lsh_w = cnt_w[7] ? ((dst_i & mask_w) >> amt_w) : (dst_i << amt_w);
    assign ash_w = cnt_w[7] ? 32'(b_s >>> amt_w) : (dst_i << amt_w);
    assign rot_l_w = cnt_w[7] ? 5'(nbits_w - {1'b0, amt_w}) : amt_w;
    assign rot_w = ((dst_i & mask_w) << rot_l_w) |
                   ((dst_i & mask_w) >> 5'(nbits_w - {1'b0, rot_l_w}));

    wire logic [31:0] bsel_w;
    wire logic [31:0] bmod_w;
    assign bsel_w = 32'h1 << src_i[4:0];
    assign bmod_w = (bt_mode_i == cie_pkg::BT_SET) ? (dst_i | bsel_w) :
                    (bt_mode_i == cie_pkg::BT_CLR) ? (dst_i & ~bsel_w) :
                    (bt_mode_i == cie_pkg::BT_INV) ? (dst_i ^ bsel_w) : dst_i;

    wire logic [63:0] fmask_w;
    wire logic [31:0] fread_w;
    wire logic [31:0] fwrite_w;
    assign fmask_w  = (64'h1 << flen_i) - 64'h1;
    assign fread_w  = 32'(({ext_i, src_i} >> fpos_i) & fmask_w);
    assign fwrite_w = (dst_i & ~32'(fmask_w << fpos_i)) |
                      32'((({32'h0, src_i}) & fmask_w) << fpos_i);

    wire logic [31:0] astep_w;
    wire logic        in_bounds_w;
    assign astep_w     = 32'(dst_i * src_i) + ext_i;
    assign in_bounds_w = ($signed(ext_i) >= $signed(src_i)) &&
                         ($signed(ext_i) <= $signed(dst_i));

    wire logic        priv_w;
    assign priv_w = ((op_i == cie_pkg::OP_DREG_LD || op_i == cie_pkg::OP_DREG_ST) &&
                     (dreg_i == cie_pkg::DREG_STATE || dreg_i == cie_pkg::DREG_VBASE)) ||
                    ((op_i == cie_pkg::OP_SBITS_SET || op_i == cie_pkg::OP_SBITS_CLR) &&
                     len_i != cie_pkg::LEN_BYTE);

    // ------------------------------------------------------------
    // Single-cycle result select
    // ------------------------------------------------------------
    logic [31:0] alu_w;
    logic [31:0] alu_hi_w;
    always_comb begin
        alu_hi_w = 32'h0;
        case (op_i)
            cie_pkg::OP_QUICK:    alu_w = {{28{short_i[3]}}, short_i};
            cie_pkg::OP_ZEXT:     alu_w = src_i & mask_w;
            cie_pkg::OP_SEXT:     alu_w = a_s;
            cie_pkg::OP_ADDC:     alu_w = addc_w[31:0];
            cie_pkg::OP_SUBC:     alu_w = subc_w[31:0];
            cie_pkg::OP_ZRATIO:   alu_w = zq_w;
            cie_pkg::OP_ZRESID:   alu_w = zr_w;
            cie_pkg::OP_FRATIO:   alu_w = fq_w;
            cie_pkg::OP_FRESID:   alu_w = fr_w;
            cie_pkg::OP_WIDEMUL: begin
                alu_w    = 32'(wmul_w & {32'h0, mask_w});
                alu_hi_w = 32'((wmul_w >> nbits_w) & {32'h0, mask_w});
            end
            cie_pkg::OP_WIDEDIV: begin
                alu_w    = wdiv_q_w;
                alu_hi_w = wdiv_r_w;
            end
            cie_pkg::OP_LSBINV:   alu_w = src_i ^ 32'h1;
            cie_pkg::OP_ALLINV:   alu_w = ~src_i;
            cie_pkg::OP_CONDSAVE: alu_w = {31'h0, cond_i};
            cie_pkg::OP_LSHIFT:   alu_w = lsh_w;
            cie_pkg::OP_ASHIFT:   alu_w = ash_w;
            cie_pkg::OP_ROT:      alu_w = rot_w;
            cie_pkg::OP_BITTEST:  alu_w = bmod_w;
            cie_pkg::OP_FREAD:    alu_w = fread_w;
            cie_pkg::OP_FWRITE:   alu_w = fwrite_w;
            cie_pkg::OP_ASTEP:    alu_w = astep_w;
            default:              alu_w = src_i;
        endcase
    end

    // ------------------------------------------------------------
    // String and block engine
    // ------------------------------------------------------------
    cie_pkg::cie_state_type state_reg;
    cie_pkg::cie_state_type state_next;
    logic [31:0] cnt_reg;
    logic [31:0] p1_reg;
    logic [31:0] p2_reg;
    logic [7:0]  elem_reg;
    logic        tphase_reg;
    logic [4:0]  sop_reg;
    logic        bwd_reg;
    logic [1:0]  sopt_reg;
    logic        xl_reg;
    logic [31:0] tab_reg;
    logic [7:0]  val_reg;
    logic        neq_reg;
    wire logic   is_str_w;
    wire logic   is_blk_w;
    wire logic   stop_w;
    wire logic [31:0] step_w;
    wire logic [7:0]  key_w;
    assign is_str_w = (op_i == cie_pkg::OP_STR_COPY) || (op_i == cie_pkg::OP_STR_CMP) ||
                      (op_i == cie_pkg::OP_STR_SKIP);
    assign is_blk_w = (op_i == cie_pkg::OP_BLK_COPY) || (op_i == cie_pkg::OP_BLK_CMP);
    assign step_w = bwd_reg ? 32'hffff_ffff : 32'h1;
    assign key_w  = mem_rdata_i;
    assign stop_w = (sopt_reg == cie_pkg::OPT_UNTIL && key_w == val_reg) ||
                    (sopt_reg == cie_pkg::OPT_WHILE && key_w != val_reg);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            cie_pkg::ST_IDLE: if (start_i && (is_str_w || is_blk_w)) begin
                state_next = ((is_str_w ? r0_i : ext_i) == 32'h0) ? cie_pkg::ST_DONE
                                                                  : cie_pkg::ST_READ;
            end
            cie_pkg::ST_READ: if (mem_ack_i && !(xl_reg && !tphase_reg)) begin
                if (stop_w)
                    state_next = cie_pkg::ST_DONE;
                else if (sop_reg == cie_pkg::OP_STR_SKIP)
                    state_next = (cnt_reg == 32'h1) ? cie_pkg::ST_DONE : cie_pkg::ST_READ;
                else
                    state_next = cie_pkg::ST_WRIT;
            end
            cie_pkg::ST_WRIT: if (mem_ack_i) begin
                state_next = (cnt_reg == 32'h1 || (mem_we_o == 1'b0 && mem_rdata_i != elem_reg))
                             ? cie_pkg::ST_DONE : cie_pkg::ST_READ;
            end
            cie_pkg::ST_DONE: state_next = cie_pkg::ST_IDLE;
            default:          state_next = cie_pkg::ST_IDLE;
        endcase
    end

    wire logic copy_w;
    assign copy_w = (sop_reg == cie_pkg::OP_STR_COPY) || (sop_reg == cie_pkg::OP_BLK_COPY);

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= cie_pkg::ST_IDLE;
            {cnt_reg, p1_reg, p2_reg, tab_reg} <= {4{32'h0}};
            {elem_reg, val_reg} <= 16'h0;
            {tphase_reg, bwd_reg, xl_reg, neq_reg} <= 4'h0;
            sop_reg  <= 5'h0;
            sopt_reg <= cie_pkg::OPT_NONE;
        end else begin
            state_reg <= state_next;
            if (state_reg == cie_pkg::ST_IDLE && start_i) begin
                cnt_reg  <= is_str_w ? r0_i : ext_i;
                p1_reg   <= is_str_w ? r1_i : src_i;
                p2_reg   <= is_str_w ? r2_i : dst_i;
                tab_reg  <= r3_i;
                val_reg  <= r4_i[7:0];
                bwd_reg  <= is_str_w & backward_i;
                sopt_reg <= is_str_w ? str_opt_i : cie_pkg::OPT_NONE;
                xl_reg   <= is_str_w & translate_i;
                sop_reg  <= op_i;
                tphase_reg <= 1'b0;
                neq_reg  <= 1'b0;
            end else if (state_reg == cie_pkg::ST_READ && mem_ack_i) begin
                if (xl_reg && !tphase_reg) begin
                    tphase_reg <= 1'b1;
                end else begin
                    tphase_reg <= 1'b0;
                    elem_reg   <= key_w;
                    if (sop_reg == cie_pkg::OP_STR_SKIP && !stop_w) begin
                        cnt_reg <= cnt_reg - 32'h1;
                        p1_reg  <= p1_reg + step_w;
                    end
                end
            end else if (state_reg == cie_pkg::ST_WRIT && mem_ack_i) begin
                cnt_reg <= cnt_reg - 32'h1;
                p1_reg  <= p1_reg + step_w;
                p2_reg  <= p2_reg + step_w;
                neq_reg <= !copy_w && (mem_rdata_i != elem_reg);
            end
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    wire logic [31:0] taddr_w;
    assign taddr_w = tab_reg + {24'h0, mem_rdata_i};
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {mem_req_o, mem_we_o, done_o, carry_o, flag_o, trap_o} <= 6'h0;
            {mem_addr_o, res_o, res_hi_o, r0_o, r1_o, r2_o} <= {6{32'h0}};
            mem_wdata_o <= 8'h0;
        end else begin
            mem_req_o   <= (state_next == cie_pkg::ST_READ) || (state_next == cie_pkg::ST_WRIT);
            mem_we_o    <= (state_next == cie_pkg::ST_WRIT) && copy_w;
            mem_wdata_o <= (state_reg == cie_pkg::ST_READ) ? key_w : mem_wdata_o;
            mem_addr_o  <= (state_reg == cie_pkg::ST_READ && mem_ack_i && xl_reg && !tphase_reg)
                           ? taddr_w :
                           (state_next == cie_pkg::ST_WRIT) ? p2_reg :
                           (state_reg == cie_pkg::ST_IDLE) ? (is_str_w ? r1_i : src_i) :
                           mem_ack_i ? p1_reg + step_w : mem_addr_o;
            done_o <= (state_reg == cie_pkg::ST_DONE) ||
                      (state_reg == cie_pkg::ST_IDLE && start_i && !is_str_w && !is_blk_w);
            r0_o <= cnt_reg;
            r1_o <= p1_reg;
            r2_o <= p2_reg;
            if (state_reg == cie_pkg::ST_DONE) begin
                flag_o <= neq_reg;
            end
            if (state_reg == cie_pkg::ST_IDLE && start_i && !is_str_w && !is_blk_w) begin
                res_o    <= (op_i == cie_pkg::OP_SEXT) ? alu_w : alu_w & mask_w;
                res_hi_o <= alu_hi_w;
                carry_o  <= carry_out_w;
                trap_o   <= priv_w && user_mode_i;
                flag_o   <= (op_i == cie_pkg::OP_BITTEST) ? ((dst_i & bsel_w) != 32'h0) :
                            (op_i == cie_pkg::OP_BOUNDS) ? !in_bounds_w : div_zero_w;
            end
        end
    end
endmodule : cie_exec

// *** testbench/cie_exec_monitor.sv ***
`timescale 1ns/10ps
module cie_exec_monitor (
    // Clock and reset
    input wire logic        mclk_i,
    input wire logic        arst_n_i,
    // Command
    input wire logic        start_i,
    input wire logic [4:0]  op_i,
    input wire logic [1:0]  len_i,
    input wire logic [31:0] src_i,
    input wire logic [31:0] dst_i,
    input wire logic [3:0]  short_i,
    input wire logic        cond_i,
    input wire logic        carry_i,
    input wire logic [3:0]  dreg_i,
    input wire logic        user_mode_i,
    input wire logic [31:0] r0_i,
    // Memory and results
    input wire logic        mem_req_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic        mem_ack_i,
    input wire logic        done_o,
    input wire logic [31:0] res_o,
    input wire logic        carry_o,
    input wire logic        trap_o
);
    // ------------------------------------------------------------
    // Acceptance tracking
    // ------------------------------------------------------------
    logic busy_reg;
    logic take;
    assign take = start_i && !busy_reg;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_reg <= 1'b0;
        end else if (take) begin
            busy_reg <= 1'b1;
        end else if (done_o) begin
            busy_reg <= 1'b0;
        end
    end
    default clocking dc @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_alu(logic [4:0] op);
        take && op_i == op && len_i == cie_pkg::LEN_DBL;
    endsequence
    a_done_pulse: assert property (done_o |=> !done_o) else $error("done too long");
    a_quick_extend: assert property (s_alu(cie_pkg::OP_QUICK) |=> done_o &&
        res_o == {{28{$past(short_i[3])}}, $past(short_i)}) else $error("quick move wrong");
    a_lsb_invert: assert property (s_alu(cie_pkg::OP_LSBINV) |=>
        res_o == ($past(src_i) ^ 32'h1)) else $error("lsb invert wrong");
    a_all_invert: assert property (s_alu(cie_pkg::OP_ALLINV) |=>
        res_o == ~$past(src_i)) else $error("all invert wrong");
    a_cond_save: assert property (s_alu(cie_pkg::OP_CONDSAVE) |=>
        res_o == {31'h0, $past(cond_i)}) else $error("condition save wrong");
    a_carry_sum: assert property (s_alu(cie_pkg::OP_ADDC) |=> {carry_o, res_o} ==
        {1'b0, $past(dst_i)} + {1'b0, $past(src_i)} + {32'h0, $past(carry_i)})
        else $error("add with carry wrong");
    a_priv_trap: assert property (take && user_mode_i && (op_i == cie_pkg::OP_DREG_LD ||
        op_i == cie_pkg::OP_DREG_ST) && (dreg_i == cie_pkg::DREG_STATE ||
        dreg_i == cie_pkg::DREG_VBASE) |=> trap_o) else $error("no privilege trap");
    a_byte_free: assert property (take && op_i == cie_pkg::OP_SBITS_SET &&
        len_i == cie_pkg::LEN_BYTE |=> !trap_o) else $error("byte state set trapped");
    a_zero_count: assert property (take && op_i == cie_pkg::OP_STR_COPY &&
        r0_i == 32'h0 |-> ##2 done_o) else $error("zero count late");
    a_mem_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o &&
        $stable(mem_addr_o)) else $error("request dropped");
endmodule : cie_exec_monitor
bind cie_exec cie_exec_monitor u_mon (.*);

// *** testbench/tb_cpu_instruction_execution.sv ***
`timescale 1ns/10ps
module tb_cpu_instruction_execution;
    // ------------------------------------------------------------
    // Signals, memory and model state
    // ------------------------------------------------------------
    logic        mclk_i, arst_n_i, start_i, cond_i, carry_i, user_mode_i;
    logic        backward_i, translate_i, mem_ack_i, mem_req_o, mem_we_o;
    logic        done_o, carry_o, flag_o, trap_o;
    logic [4:0]  op_i, fpos_i;
    logic [5:0]  flen_i;
    logic [3:0]  short_i, dreg_i;
    logic [1:0]  len_i, bt_mode_i, str_opt_i;
    logic [7:0]  mem_rdata_i, mem_wdata_o;
    logic [31:0] src_i, dst_i, ext_i, r0_i, r1_i, r2_i, r3_i, r4_i, e, seed;
    logic [31:0] mem_addr_o, res_o, res_hi_o, r0_o, r1_o, r2_o;
    logic [7:0]  mem [0:63];
    logic [7:0]  mm [0:63];
    logic [4:0]  ops [9] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0c, 5'h0d, 5'h0e};
    int          fail_count, checked, i;
    cie_exec dut (.*);
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        mem_ack_i <= mem_req_o && !mem_ack_i;
        mem_rdata_i <= (mem_req_o && !mem_ack_i) ? mem[mem_addr_o[5:0]] : ~mem_rdata_i;
        if (mem_req_o && mem_we_o && !mem_ack_i) begin
            mem[mem_addr_o[5:0]] <= mem_wdata_o;
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [31:0] mdl(input logic [4:0] op, input logic [31:0] s, d);
        longint a, b, c, q, r;
        logic   fix;
        a = longint'($signed(d));
        b = longint'($signed(s));
        c = longint'($signed(s[7:0]));
        q = (b == 0) ? 0 : a / b;
        r = (b == 0) ? 0 : a % b;
        fix = r != 0 && ((r < 0) != (b < 0));
        case (op)
            cie_pkg::OP_QUICK:    return {{28{short_i[3]}}, short_i};
            cie_pkg::OP_ZEXT:     return {24'h0, s[7:0]};
            cie_pkg::OP_SEXT:     return {{24{s[7]}}, s[7:0]};
            cie_pkg::OP_ADDC:     return d + s + carry_i;
            cie_pkg::OP_SUBC:     return d - s - carry_i;
            cie_pkg::OP_ZRATIO:   return q[31:0];
            cie_pkg::OP_ZRESID:   return r[31:0];
            cie_pkg::OP_FRATIO:   return fix ? q[31:0] - 32'h1 : q[31:0];
            cie_pkg::OP_FRESID:   return fix ? r[31:0] + s : r[31:0];
            cie_pkg::OP_LSBINV:   return s ^ 32'h1;
            cie_pkg::OP_ALLINV:   return ~s;
            cie_pkg::OP_CONDSAVE: return {31'h0, cond_i};
            cie_pkg::OP_LSHIFT:   return (c < 0) ? d >> -c : d << c;
            cie_pkg::OP_ASHIFT:   return (c < 0) ? (d[31] ? ~(~d >> -c) : d >> -c) : d << c;
            cie_pkg::OP_ROT:      return (d << c[4:0]) | (d >> (6'd32 - c[4:0]));
            default:              return 32'h0;
        endcase
    endfunction : mdl
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    // x: short, cond, carry, user, selector
    task automatic go(input logic [4:0] op, input logic [1:0] len, input logic [31:0] s, d, x);
        int n;
        @(posedge mclk_i);
        {op_i, len_i, src_i, dst_i} <= {op, len, s, d};
        {short_i, cond_i, carry_i, user_mode_i, dreg_i} <= {x[3:0], x[4], x[5], x[6], x[11:8]};
        {r3_i, ext_i, start_i} <= {rnd(), rnd(), 1'b1};
        @(posedge mclk_i);
        start_i <= 1'b0;
        n = 0;
        do begin
            @(negedge mclk_i);
            n++;
        end while (done_o !== 1'b1 && n < 400);
        if (done_o !== 1'b1) begin
            fail_count++;
            end_sim();
        end
    endtask : go
    task automatic str(input logic [1:0] opt, input logic bwd, input int n, p1, p2, k);
        for (int a = 0; a < 64; a++) mm[a] = mem[a];
        @(posedge mclk_i);
        {r0_i, r1_i, r2_i, r4_i} <= {32'(n), 32'(p1), 32'(p2), 32'(k)};
        {str_opt_i, backward_i} <= {opt, bwd};
        while (n != 0 && !(opt == cie_pkg::OPT_UNTIL && mm[p1[5:0]] == k[7:0]) &&
               !(opt == cie_pkg::OPT_WHILE && mm[p1[5:0]] != k[7:0])) begin
            mm[p2[5:0]] = mm[p1[5:0]];
            n--;
            p1 = bwd ? p1 - 1 : p1 + 1;
            p2 = bwd ? p2 - 1 : p2 + 1;
        end
        go(cie_pkg::OP_STR_COPY, cie_pkg::LEN_BYTE, 32'h0, 32'h0, 32'h0);
        chk("r0", 32'(n), r0_o);
        chk("r1", 32'(p1), r1_o);
        chk("r2", 32'(p2), r2_o);
        for (int a = 0; a < 64; a++) chk("mem", {24'h0, mm[a]}, {24'h0, mem[a]});
    endtask : str
    initial begin
        {seed, fail_count, checked} = {32'h998aa3c4, 64'h0};
        {arst_n_i, start_i, cond_i, carry_i, user_mode_i, backward_i, translate_i} = '0;
        {op_i, len_i, short_i, dreg_i, bt_mode_i, fpos_i, flen_i, str_opt_i} = '0;
        {src_i, dst_i, ext_i, r0_i, r1_i, r2_i, r3_i, r4_i, mem_ack_i, mem_rdata_i} = '0;
        for (i = 0; i < 64; i++) mem[i] = i[7:0] + 8'h10;
        repeat (2) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        for (i = 0; i < 16; i++) begin
            go(cie_pkg::OP_QUICK, cie_pkg::LEN_DBL, 32'h0, 32'h0, 32'(i));
            chk("quick", mdl(op_i, src_i, dst_i), res_o);
        end
        for (i = 0; i < 2; i++) begin
            go(i ? cie_pkg::OP_SEXT : cie_pkg::OP_ZEXT, cie_pkg::LEN_BYTE, 32'hc3, 32'h0, 32'h0);
            e = mdl(op_i, src_i, dst_i);
            chk("extend", {16'h0, e[15:0]}, {16'h0, res_o[15:0]});
        end
        for (i = 0; i < 45; i++) begin
            go(ops[i % 9], cie_pkg::LEN_DBL, (i % 4 == 3) ? 32'h0 : rnd(), rnd(), rnd());
            chk("alu", mdl(op_i, src_i, dst_i), res_o);
        end
        for (i = 0; i < 6; i++) begin
            go(cie_pkg::OP_LSHIFT + 5'(i / 2), cie_pkg::LEN_DBL, (i % 2) ? 32'hfd : 32'h3,
               32'h800000f1, 32'h0);
            chk("shift", mdl(op_i, src_i, dst_i), res_o);
        end
        for (i = 0; i < 32; i++) begin
            e = (i[4:3] == 2'h1) ? 32'ha : (i[4:3] == 2'h2) ? 32'hb : 32'(i[4:3]);
            go(cie_pkg::OP_DREG_LD + 5'(i[1:0]), i[3] ? cie_pkg::LEN_BYTE : cie_pkg::LEN_DBL,
               rnd(), rnd(), (e << 8) | (32'(i[2]) << 6));
            chk("trap", {31'h0, i[2] && (i[1] ? !i[3] : e[3])}, {31'h0, trap_o});
        end
        str(cie_pkg::OPT_UNTIL, 1'b0, 5, 0, 32, 32'h12);
        str(cie_pkg::OPT_WHILE, 1'b1, 6, 20, 48, 32'h24);
        str(cie_pkg::OPT_NONE, 1'b1, 3, 10, 60, 0);
        str(cie_pkg::OPT_NONE, 1'b0, 0, 1, 2, 0);
        end_sim();
    end
endmodule : tb_cpu_instruction_execution
